// ===== cpu_shift_flag_load_ops_tb.sv
// Self-checking bench for the shift, flag and load execution unit
`timescale 1ns/1ps
module cpu_shift_flag_load_ops_tb import sfl_pkg::*;;
	logic       mclk, rst, vld, rdy, done, mrd, we;
	sfl_cmd_t   cmd;
	logic [7:0] flags, rdata, wdata, rfo, mf;
	logic [15:0] maddr;
	logic [4:0] waddr, raddr;
	logic [7:0] mrf [32];
	int         err_count, num_checks, i, o, p, d;

	sfl_core dut (.mclk_i(mclk), .rst_i(rst), .cmd_valid_i(vld), .cmd_i(cmd),
		.cmd_ready_o(rdy), .done_o(done), .flags_o(flags), .mem_rd_o(mrd),
		.mem_addr_o(maddr), .mem_rdata_i(rdata), .rf_we_i(we), .rf_waddr_i(waddr),
		.rf_wdata_i(wdata), .rf_raddr_i(raddr), .rf_rdata_o(rfo));
	sfl_mem_model mem (.mclk_i(mclk), .rst_i(rst), .rd_i(mrd), .addr_i(maddr),
		.rdata_o(rdata));

	initial begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(string n, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			$display("FAIL %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask

	task wr(int r, logic [7:0] v);
		vld = 0;
		we = 1;
		waddr = 5'(r);
		wdata = v;
		@(posedge mclk);
		#2;
		we = 0;
		mrf[r] = v;
	endtask

	task chk_reg(int r);
		vld = 0;
		raddr = 5'(r);
		@(posedge mclk);
		#2;
		chk("reg", 16'(mrf[r]), 16'(rfo));
	endtask

	// Left with valid high, so the caller sets the next request
	task op(int c, int r, int b, int f);
		logic [7:0] v;
		logic [7:0] x;
		v = mrf[r];
		x = v;
		cmd = '0;
		cmd.op = sfl_op_t'(4'(c));
		cmd.rd = 5'(r);
		cmd.bsel = 3'(b);
		cmd.fsel = 3'(f);
		vld = 1;
		@(posedge mclk);
		#2;
		// Flag bits: 0 C, 1 Z, 2 N, 3 V, 6 T
		case (c)
			1, 2: begin
				x = {(c == 1) ? mf[0] : v[7], v[7:1]};
				mf[0] = v[0];
				mf[2] = x[7];
				mf[3] = x[7] ^ v[0];
				mf[1] = (x == 8'h00);
			end
			3: x = {v[3:0], v[7:4]};
			4: mf[6] = v[b];
			5: x[b] = mf[6];
			6: mf[f] = 1'b1;
			7: mf[f] = 1'b0;
			default: ;
		endcase
		mrf[r] = x;
		// No-op and undefined codes finish nothing
		chk("done", 16'(c >= 1 && c <= 7), 16'(done));
		chk("flags", 16'(mf), 16'(flags));
	endtask

	task ld(int c, int r, int pp, int q);
		int lo;
		logic [15:0] pv;
		logic [15:0] a;
		lo = 26 + 2 * pp;
		pv = {mrf[lo + 1], mrf[lo]};
		a = (c == 8) ? pv : (c == 9) ? pv - 16'h0001 : pv + 16'(q);
		cmd = '0;
		cmd.op = sfl_op_t'(4'(c));
		cmd.rd = 5'(r);
		cmd.ptr = 2'(pp);
		cmd.disp = 6'(q);
		vld = 1;
		@(posedge mclk);
		#2;
		chk("mem_rd", 16'h0001, 16'(mrd));
		chk("addr", a, maddr);
		chk("ready", 16'h0000, 16'(rdy));
		// A flag toggle offered while busy must be ignored
		cmd.op = mf[6] ? SFL_OP_FCLR : SFL_OP_FSET;
		cmd.fsel = 3'h6;
		@(posedge mclk);
		#2;
		pv = (c == 8) ? pv + 16'h0001 : (c == 9) ? a : pv;
		mrf[lo] = pv[7:0];
		mrf[lo + 1] = pv[15:8];
		mrf[r] = a[7:0] ^ a[15:8] ^ 8'hA5;
		chk("done", 16'h0001, 16'(done));
		chk("flags", 16'(mf), 16'(flags));
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst = 1;
		vld = 0;
		cmd = '0;
		we = 0;
		waddr = 0;
		wdata = 0;
		raddr = 0;
		mf = 8'h00;
		err_count = 0;
		num_checks = 0;
		for (i = 0; i < 32; i++) mrf[i] = 8'h00;
		void'($urandom(99));
		repeat (8) @(posedge mclk);
		#2;
		rst = 0;
		chk("flags", 16'h0000, 16'(flags));
		chk("ready", 16'h0001, 16'(rdy));
		$display("test reset ended");
		for (i = 0; i < 12; i++) begin
			d = $urandom % 32;
			wr(d, (i == 0) ? 8'h01 : 8'($urandom));
			op(1, d, 0, 0);
			op(2, d, 0, 0);
			op(3, d, 0, 0);
			op(4, d, $urandom % 8, 0);
			op(5, d, $urandom % 8, 0);
			chk_reg(d);
		end
		$display("test shifts and bit moves ended");
		for (i = 0; i < 8; i++) begin
			op(6, d, 0, i);
			op(7, d, 0, i);
			op(6, d, 0, i);
			op(0, d, 0, i);
			op(11 + i % 5, d, i, i);
		end
		$display("test flag forcing ended");
		for (i = 0; i < 4; i++) begin
			for (p = 0; p < 3; p++) begin
				for (o = 8; o < 11; o++) begin
					wr(26 + 2 * p, (i == 0) ? 8'h00 : 8'($urandom));
					wr(27 + 2 * p, (i == 0) ? 8'h00 : 8'($urandom));
					d = $urandom % 26;
					ld(o, d, p, (i == 0) ? 63 : $urandom % 64);
					chk_reg(d);
					chk_reg(26 + 2 * p);
					chk_reg(27 + 2 * p);
				end
			end
		end
		$display("test indirect loads ended");
		end_of_test;
	end

	initial begin
		#(50 * 5000);
		err_count++;
		end_of_test;
	end
endmodule

// ===== sfl_consts.svh
// Constants for the shift, flag and load execution unit
`ifndef SFL_CONSTS_SVH
`define SFL_CONSTS_SVH

// ****************************************
// Status flag bit positions
// ****************************************
`define SFL_FLAG_C 3'h0
`define SFL_FLAG_Z 3'h1
`define SFL_FLAG_N 3'h2
`define SFL_FLAG_V 3'h3
`define SFL_FLAG_S 3'h4
`define SFL_FLAG_H 3'h5
`define SFL_FLAG_T 3'h6
`define SFL_FLAG_I 3'h7
`define SFL_FLAGS_RESET 8'h00

// ****************************************
// Register file layout
// ****************************************
`define SFL_NREG 32
`define SFL_PTR_BASE 5'h1A
`define SFL_REG_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define SFL_LOAD_CYCLES 2

`endif

// ===== sfl_core.sv
// Execution unit for shifts, nibble swap, flag moves and indirect loads
// Summary of operation
// - rotate right through carry, flags Z C N V
// - copy register bit into transfer flag
// - copy transfer flag into register bit
// - force sign flag one or zero
// - force overflow flag one or zero
// - force transfer flag one or zero
// - force half carry flag one or zero
// - load then pointer plus one, two cycles
// - pointer minus one then load, two cycles
// - load at pointer plus offset, pointer kept
`timescale 1ns/1ps
`include "sfl_consts.svh"
module sfl_core
	import sfl_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        cmd_valid_i,
	input  sfl_cmd_t         cmd_i,
	output logic             cmd_ready_o,
	output logic             done_o,
	output logic [7:0]       flags_o,
	output logic             mem_rd_o,
	output logic [15:0]      mem_addr_o,
	input  wire logic [7:0]  mem_rdata_i,
	input  wire logic        rf_we_i,
	input  wire logic [4:0]  rf_waddr_i,
	input  wire logic [7:0]  rf_wdata_i,
	input  wire logic [4:0]  rf_raddr_i,
	output logic [7:0]       rf_rdata_o
);
	// ****************************************
	// State
	// ****************************************
	logic [7:0]  rf_reg [`SFL_NREG];
	logic [7:0]  rf_next [`SFL_NREG];
	logic [7:0]  flags_reg, flags_next;
	sfl_state_t  state_reg, state_next;
	logic [15:0] addr_reg, addr_next;
	logic [15:0] ptrval_reg, ptrval_next;
	logic        ptr_we_reg, ptr_we_next;
	logic [4:0]  ld_rd_reg, ld_rd_next;
	logic [1:0]  ld_ptr_reg, ld_ptr_next;
	logic        done_reg, done_next;
	logic [7:0]  rdata_reg, rdata_next;
	logic [7:0]  rd_val;
	logic [15:0] ptr_cur;
	logic        accept;
	sfl_shift_t  sh;

	function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
		ptr_lo = `SFL_PTR_BASE + {2'h0, sel, 1'b0};
	endfunction

	function automatic logic [15:0] ptr_read(input logic [1:0] sel);
		ptr_read = {rf_reg[ptr_lo(sel) + 5'h01], rf_reg[ptr_lo(sel)]};
	endfunction

	assign rd_val      = rf_reg[cmd_i.rd];
	// Array read inline: an assign does not wake on reads inside a function
	assign ptr_cur     = {rf_reg[ptr_lo(cmd_i.ptr) + 5'h01], rf_reg[ptr_lo(cmd_i.ptr)]};
	assign cmd_ready_o = (state_reg == SFL_ST_IDLE);
	assign accept      = cmd_valid_i && cmd_ready_o;
	assign done_o      = done_reg;
	assign flags_o     = flags_reg;
	assign mem_rd_o    = (state_reg == SFL_ST_LOAD);
	assign mem_addr_o  = addr_reg;
	assign rf_rdata_o  = rdata_reg;

	sfl_shift_unit u_shift (
		.arith_i (cmd_i.op == SFL_OP_ASR),
		.val_i   (rd_val),
		.carry_i (flags_reg[`SFL_FLAG_C]),
		.out_o   (sh)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		rf_next     = rf_reg;
		flags_next  = flags_reg;
		state_next  = state_reg;
		addr_next   = addr_reg;
		ptrval_next = ptrval_reg;
		ptr_we_next = ptr_we_reg;
		ld_rd_next  = ld_rd_reg;
		ld_ptr_next = ld_ptr_reg;
		done_next   = 1'b0;
		rdata_next  = rf_reg[rf_raddr_i];
		// Side port writes first so a same-cycle core write wins
		if (rf_we_i) begin
			rf_next[rf_waddr_i] = rf_wdata_i;
		end
		case (state_reg)
			SFL_ST_IDLE: begin
				if (cmd_valid_i) begin
					done_next   = (cmd_i.op != SFL_OP_NOP);
					ld_rd_next  = cmd_i.rd;
					ld_ptr_next = cmd_i.ptr;
					case (cmd_i.op)
						SFL_OP_ROR, SFL_OP_ASR: begin
							rf_next[cmd_i.rd]       = sh.res;
							flags_next[`SFL_FLAG_C] = sh.c;
							flags_next[`SFL_FLAG_N] = sh.n;
							flags_next[`SFL_FLAG_V] = sh.v;
							flags_next[`SFL_FLAG_Z] = sh.z;
						end
						SFL_OP_SWAP: begin
							rf_next[cmd_i.rd] = {rd_val[3:0], rd_val[7:4]};
						end
						SFL_OP_BST: begin
							flags_next[`SFL_FLAG_T] = rd_val[cmd_i.bsel];
						end
						SFL_OP_BLD: begin
							rf_next[cmd_i.rd][cmd_i.bsel] = flags_reg[`SFL_FLAG_T];
						end
						SFL_OP_FSET: begin
							flags_next[cmd_i.fsel] = 1'b1;
						end
						SFL_OP_FCLR: begin
							flags_next[cmd_i.fsel] = 1'b0;
						end
						SFL_OP_LD_POST: begin
							addr_next   = ptr_cur;
							ptrval_next = ptr_cur + 16'h0001;
							ptr_we_next = 1'b1;
							done_next   = 1'b0;
							state_next  = SFL_ST_LOAD;
						end
						SFL_OP_LD_PRE: begin
							addr_next   = ptr_cur - 16'h0001;
							ptrval_next = ptr_cur - 16'h0001;
							ptr_we_next = 1'b1;
							done_next   = 1'b0;
							state_next  = SFL_ST_LOAD;
						end
						SFL_OP_LD_DISP: begin
							addr_next   = ptr_cur + {10'h000, cmd_i.disp};
							ptrval_next = ptr_cur;
							ptr_we_next = 1'b0;
							done_next   = 1'b0;
							state_next  = SFL_ST_LOAD;
						end
						default: begin
							done_next = 1'b0;
						end
					endcase
				end
			end
			SFL_ST_LOAD: begin
				// Pointer first, loaded data last: data wins if rd is a pointer half
				if (ptr_we_reg) begin
					rf_next[ptr_lo(ld_ptr_reg)]         = ptrval_reg[7:0];
					rf_next[ptr_lo(ld_ptr_reg) + 5'h01] = ptrval_reg[15:8];
				end
				rf_next[ld_rd_reg] = mem_rdata_i;
				done_next          = 1'b1;
				state_next         = SFL_ST_IDLE;
			end
			default: begin
				state_next = SFL_ST_IDLE;
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			for (int i = 0; i < `SFL_NREG; i++) begin
				rf_reg[i] <= `SFL_REG_RESET;
			end
			flags_reg  <= `SFL_FLAGS_RESET;
			state_reg  <= SFL_ST_IDLE;
			addr_reg   <= 16'h0000;
			ptrval_reg <= 16'h0000;
			ptr_we_reg <= 1'b0;
			ld_rd_reg  <= 5'h00;
			ld_ptr_reg <= 2'h0;
			done_reg   <= 1'b0;
			rdata_reg  <= 8'h00;
		end else begin
			rf_reg     <= rf_next;
			flags_reg  <= flags_next;
			state_reg  <= state_next;
			addr_reg   <= addr_next;
			ptrval_reg <= ptrval_next;
			ptr_we_reg <= ptr_we_next;
			ld_rd_reg  <= ld_rd_next;
			ld_ptr_reg <= ld_ptr_next;
			done_reg   <= done_next;
			rdata_reg  <= rdata_next;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// Snapshot of the command and operands at acceptance
	sfl_cmd_t    h_cmd;
	logic [7:0]  h_val;
	logic [7:0]  h_flags;
	logic [15:0] h_ptr;
	always_ff @(posedge mclk_i) begin
		if (accept) begin
			h_cmd   <= cmd_i;
			h_val   <= rd_val;
			h_flags <= flags_reg;
			h_ptr   <= ptr_cur;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_issue(sfl_op_t code);
		accept && cmd_i.op == code && !rf_we_i;
	endsequence
	sequence s_load_at(logic [15:0] a);
		mem_rd_o && !cmd_ready_o && mem_addr_o == a;
	endsequence

	property p_ror;
		s_issue(SFL_OP_ROR) |=> rf_reg[h_cmd.rd] == {h_flags[0], h_val[7:1]}
			&& flags_reg[`SFL_FLAG_C] == h_val[0] && flags_reg[7:4] == h_flags[7:4];
	endproperty
	a_ror: assert property (p_ror) else $error("rotate result wrong");

	property p_asr;
		s_issue(SFL_OP_ASR) |=> rf_reg[h_cmd.rd] == {h_val[7], h_val[7:1]}
			&& flags_reg[`SFL_FLAG_V] == (h_val[7] ^ h_val[0]);
	endproperty
	a_asr: assert property (p_asr) else $error("arith shift wrong");

	property p_swap;
		s_issue(SFL_OP_SWAP) |=> rf_reg[h_cmd.rd] == {h_val[3:0], h_val[7:4]}
			&& flags_reg == h_flags;
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");

	property p_bst;
		s_issue(SFL_OP_BST) |=> flags_reg[`SFL_FLAG_T] == h_val[h_cmd.bsel]
			&& flags_reg[5:0] == h_flags[5:0] && flags_reg[7] == h_flags[7];
	endproperty
	a_bst: assert property (p_bst) else $error("bit to flag wrong");

	property p_bld;
		s_issue(SFL_OP_BLD) |=> rf_reg[h_cmd.rd][h_cmd.bsel] == h_flags[`SFL_FLAG_T]
			&& flags_reg == h_flags;
	endproperty
	a_bld: assert property (p_bld) else $error("flag to bit wrong");

	property p_force(logic [2:0] f);
		accept && cmd_i.fsel == f && (cmd_i.op == SFL_OP_FSET || cmd_i.op == SFL_OP_FCLR)
			|=> flags_reg[f] == (h_cmd.op == SFL_OP_FSET)
			&& (flags_reg ^ h_flags) == ((flags_reg[f] ^ h_flags[f]) ? 8'h01 << f : 8'h00);
	endproperty
	property p_sign_force;
		p_force(`SFL_FLAG_S);
	endproperty
	a_sign_force: assert property (p_sign_force) else $error("sign force wrong");
	property p_ovf_force;
		p_force(`SFL_FLAG_V);
	endproperty
	a_ovf_force: assert property (p_ovf_force) else $error("overflow force wrong");
	property p_xfer_force;
		p_force(`SFL_FLAG_T);
	endproperty
	a_xfer_force: assert property (p_xfer_force) else $error("xfer force wrong");
	property p_half_force;
		p_force(`SFL_FLAG_H);
	endproperty
	a_half_force: assert property (p_half_force) else $error("half force wrong");

	property p_ld_post;
		s_issue(SFL_OP_LD_POST) |=> s_load_at(h_ptr) ##1
			(done_o && cmd_ready_o && flags_reg == h_flags);
	endproperty
	a_ld_post: assert property (p_ld_post) else $error("post-inc load wrong");

	property p_ld_pre;
		s_issue(SFL_OP_LD_PRE) |=> s_load_at(h_ptr - 16'h0001) ##1
			(done_o && flags_reg == h_flags);
	endproperty
	a_ld_pre: assert property (p_ld_pre) else $error("pre-dec load wrong");

	property p_ld_disp;
		s_issue(SFL_OP_LD_DISP) ##0 cmd_i.rd < `SFL_PTR_BASE
			|=> s_load_at(h_ptr + {10'h000, h_cmd.disp}) ##1
			(done_o && ptr_read(h_cmd.ptr) == h_ptr && flags_reg == h_flags);
	endproperty
	a_ld_disp: assert property (p_ld_disp) else $error("offset load wrong");

	property p_ld_data;
		mem_rd_o |=> rf_reg[ld_rd_reg] == $past(mem_rdata_i);
	endproperty
	a_ld_data: assert property (p_ld_data) else $error("load data not written");
endmodule

// ===== sfl_mem_model.sv
// Data memory model answering the unit's indirect loads
`timescale 1ns/1ps
module sfl_mem_model (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] addr_i,
	output logic      [7:0]  rdata_o
);
	logic [7:0] last_reg;
	logic [7:0] word;
	// Contents follow the address so the bench can predict them
	assign word = addr_i[7:0] ^ addr_i[15:8] ^ 8'hA5;
	// Outside a read show the inverse of the last byte, so stale data never matches
	assign rdata_o = rd_i ? word : ~last_reg;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			last_reg <= 8'h00;
		end else if (rd_i) begin
			last_reg <= word;
		end
	end
endmodule

// ===== sfl_pkg.sv
// Types shared by the shift, flag and load execution unit
package sfl_pkg;

	typedef enum logic [3:0] {
		SFL_OP_NOP     = 4'h0,
		SFL_OP_ROR     = 4'h1,
		SFL_OP_ASR     = 4'h2,
		SFL_OP_SWAP    = 4'h3,
		SFL_OP_BST     = 4'h4,
		SFL_OP_BLD     = 4'h5,
		SFL_OP_FSET    = 4'h6,
		SFL_OP_FCLR    = 4'h7,
		SFL_OP_LD_POST = 4'h8,
		SFL_OP_LD_PRE  = 4'h9,
		SFL_OP_LD_DISP = 4'hA
	} sfl_op_t;

	typedef enum logic [1:0] {
		SFL_ST_IDLE = 2'b01,
		SFL_ST_LOAD = 2'b10
	} sfl_state_t;

	typedef struct packed {
		sfl_op_t    op;
		logic [4:0] rd;
		logic [2:0] bsel;
		logic [2:0] fsel;
		logic [1:0] ptr;
		logic [5:0] disp;
	} sfl_cmd_t;

	typedef struct packed {
		logic [7:0] res;
		logic       c;
		logic       n;
		logic       v;
		logic       z;
	} sfl_shift_t;

endpackage

// ===== sfl_shift_unit.sv
// Right shift and rotate through carry with flag results
`timescale 1ns/1ps
module sfl_shift_unit
	import sfl_pkg::*;
(
	input  wire logic       arith_i,
	input  wire logic [7:0] val_i,
	input  wire logic       carry_i,
	output sfl_shift_t      out_o
);
	always_comb begin
		out_o.res = {(arith_i ? val_i[7] : carry_i), val_i[7:1]};
		out_o.c   = val_i[0];
		out_o.n   = out_o.res[7];
		out_o.v   = out_o.res[7] ^ val_i[0];
		out_o.z   = (out_o.res == 8'h00);
	end
endmodule
